/* File: core/dcx_pkg.sv */
// package with register map, field layout and timing for the converter control
package dcx_pkg;

  // register byte addresses on the bus (one aligned word each)
  localparam logic [7:0] DCX_OFS_CFG = 8'h00; // converter_config
  localparam logic [7:0] DCX_OFS_HIGH = 8'h04; // converter_value_high
  localparam logic [7:0] DCX_OFS_LOW = 8'h08; // converter_value_low
  localparam logic [7:0] DCX_OFS_DIS0 = 8'h0C; // input_disable_first
  localparam logic [7:0] DCX_OFS_DIS1 = 8'h10; // input_disable_second
  localparam logic [7:0] DCX_OFS_STAT = 8'h14; // read-only converter state

  // configuration field positions
  localparam int DCX_CFG_AUTO_BIT = 7; // auto_trigger_on
  localparam int DCX_CFG_SEL_MSB = 6; // trigger_select, top bit
  localparam int DCX_CFG_SEL_LSB = 4; // trigger_select, low bit
  localparam int DCX_CFG_LEFT_BIT = 2; // left_adjust
  localparam int DCX_CFG_OE_BIT = 1; // output_pin_drive
  localparam int DCX_CFG_EN_BIT = 0; // converter_on
  localparam logic [7:0] DCX_CFG_WMASK = 8'hF7; // bit 3 reserved

  // implemented input-disable bits
  localparam logic [7:0] DCX_DIS0_MASK = 8'h6D; // bits 6,5,3,2,0
  localparam logic [7:0] DCX_DIS1_MASK = 8'h26; // bits 5,2,1

  // status word field positions
  localparam int DCX_STAT_BUSY_BIT = 10; // conversion in progress
  localparam int DCX_STAT_ARMED_BIT = 11; // staged value ready for trigger

  // reset values
  localparam logic [7:0] DCX_CFG_RST = 8'h00;
  localparam logic [7:0] DCX_HIGH_RST = 8'h00;
  localparam logic [7:0] DCX_LOW_RST = 8'h00;
  localparam logic [7:0] DCX_DIS_RST = 8'h00;
  localparam logic [9:0] DCX_CODE_RST = 10'h000;

  // trigger source codes of trigger_select
  localparam logic [2:0] DCX_TRG_CMP0 = 3'h0;
  localparam logic [2:0] DCX_TRG_CMP1 = 3'h1;
  localparam logic [2:0] DCX_TRG_EXT0 = 3'h2;
  localparam logic [2:0] DCX_TRG_T0CMP = 3'h3;
  localparam logic [2:0] DCX_TRG_T0OVF = 3'h4;
  localparam logic [2:0] DCX_TRG_T1CMPB = 3'h5;
  localparam logic [2:0] DCX_TRG_T1OVF = 3'h6;
  localparam logic [2:0] DCX_TRG_T1CAP = 3'h7;

  // timing: conversion settle time, rounded up to whole clocks
  localparam int DCX_CLK_PERIOD_NS = 50;
  localparam int DCX_SETTLE_NS = 1000;
  localparam int DCX_SETTLE_CYCLES =
    (DCX_SETTLE_NS + DCX_CLK_PERIOD_NS - 1) / DCX_CLK_PERIOD_NS;

  // bus responses
  localparam logic [1:0] DCX_RESP_OKAY = 2'h0;
  localparam logic [1:0] DCX_RESP_SLVERR = 2'h2;

  // conversion state machine, one-hot
  typedef enum logic [1:0]
  {
    DCX_CV_IDLE = 2'b01,
    DCX_CV_BUSY = 2'b10
  } dcx_conv_type;

endpackage : dcx_pkg

/* File: core/dcx_top.sv */
// converter control: config, data bytes, shadow code, trigger, input disable
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module dcx_top
#(
  parameter int SETTLE_CYCLES = dcx_pkg::DCX_SETTLE_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // register bus, write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // register bus, read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // on-chip event flags, same clock
  input wire logic [7:0] event_flags,
  // comparator pins
  input wire logic [7:0] pin_in0,
  input wire logic [7:0] pin_in1,
  output logic [7:0] pin_read0,
  output logic [7:0] pin_read1,
  output logic [7:0] buf_off0,
  output logic [7:0] buf_off1,
  // analog converter core
  output logic [9:0] conv_code,
  output logic converter_on,
  output logic output_pin_drive,
  output logic conv_start,
  output logic conv_busy
);
  import dcx_pkg::*;

  // builds the ten-bit code from the two data bytes
  function automatic logic [9:0] code_from_bytes(input logic left,
    input logic [7:0] hi, input logic [7:0] lo);
    if (left)
      code_from_bytes = {hi, lo[7:6]};
    else
      code_from_bytes = {hi[1:0], lo};
  endfunction : code_from_bytes

  // maps trigger_select to one event flag
  function automatic logic trig_pick(input logic [2:0] sel,
    input logic [7:0] flags);
    unique case (sel)
      DCX_TRG_CMP0: trig_pick = flags[0];
      DCX_TRG_CMP1: trig_pick = flags[1];
      DCX_TRG_EXT0: trig_pick = flags[2];
      DCX_TRG_T0CMP: trig_pick = flags[3];
      DCX_TRG_T0OVF: trig_pick = flags[4];
      DCX_TRG_T1CMPB: trig_pick = flags[5];
      DCX_TRG_T1OVF: trig_pick = flags[6];
      DCX_TRG_T1CAP: trig_pick = flags[7];
    endcase
  endfunction : trig_pick

  logic rst_q1; // reset release, first stage
  logic rst_n; // reset released to the clock
  logic [7:0] cfg; // converter_config
  logic [7:0] hi_byte; // converter_value_high
  logic [7:0] lo_byte; // converter_value_low
  logic [7:0] dis0; // input_disable_first
  logic [7:0] dis1; // input_disable_second
  logic aw_held; // write address captured
  logic [7:0] aw_addr; // captured write address
  logic w_held; // write data captured
  logic [7:0] w_byte; // captured low data lane
  logic w_lane0; // lane 0 strobe of captured data
  logic wr_do; // both halves present: perform write
  logic wr_en; // write with lane 0 enabled
  logic wr_map; // write address is mapped
  logic hi_write; // high data byte written
  logic lo_write; // low data byte written
  logic cfg_write; // configuration written
  logic [9:0] next_code; // code formed by this high write
  logic [9:0] staged; // value waiting for a trigger
  logic armed; // staged value may be applied
  logic flag_prev; // selected flag, one clock late
  logic sel_flag; // selected flag now
  logic trig_edge; // rising edge of selected flag
  logic trig_go; // edge accepted for a conversion
  logic en_prev; // enable, one clock late
  logic start_req; // start a conversion this clock
  dcx_conv_type state; // conversion state
  logic [15:0] settle_cnt; // clocks left in conversion
  logic [7:0] p0_s1, p0_s2, p0_s3, p0_f; // pin bank 0 sync and filter
  logic [7:0] p1_s1, p1_s2, p1_s3, p1_f; // pin bank 1 sync and filter
  logic [31:0] rd_word; // read data selected by address
  logic rd_map; // read address is mapped

  // reset release: async assert, two-flop sync release
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // write channels: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_do = aw_held && w_held;
  assign wr_en = wr_do && w_lane0;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (wr_do)
      aw_held <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end
    else if (wr_do)
      w_held <= 1'b0;
  end

  // write decode; the status word is read-only and counts as mapped
  always_comb
  begin
    wr_map = 1'b1;
    unique case (aw_addr)
      DCX_OFS_CFG, DCX_OFS_HIGH, DCX_OFS_LOW,
      DCX_OFS_DIS0, DCX_OFS_DIS1, DCX_OFS_STAT: wr_map = 1'b1;
      default: wr_map = 1'b0;
    endcase
  end

  assign hi_write = wr_en && (aw_addr == DCX_OFS_HIGH);
  assign lo_write = wr_en && (aw_addr == DCX_OFS_LOW);
  assign cfg_write = wr_en && (aw_addr == DCX_OFS_CFG);

  // write response follows both halves; unmapped gets slave error
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DCX_RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_map ? DCX_RESP_OKAY : DCX_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // configuration; reserved bit 3 is masked off on write
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cfg <= DCX_CFG_RST;
    else if (cfg_write)
      cfg <= w_byte & DCX_CFG_WMASK;
  end

  // data bytes hold what software wrote, in the chosen layout
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_byte <= DCX_HIGH_RST;
      lo_byte <= DCX_LOW_RST;
    end
    else if (hi_write)
      hi_byte <= w_byte;
    else if (lo_write)
      lo_byte <= w_byte;
  end

  // input disable registers keep only implemented bits
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dis0 <= DCX_DIS_RST;
      dis1 <= DCX_DIS_RST;
    end
    else if (wr_en && aw_addr == DCX_OFS_DIS0)
      dis0 <= w_byte & DCX_DIS0_MASK;
    else if (wr_en && aw_addr == DCX_OFS_DIS1)
      dis1 <= w_byte & DCX_DIS1_MASK;
  end

  // buffer-off controls go straight from the registers
  assign buf_off0 = dis0;
  assign buf_off1 = dis1;

  // pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p0_s1 <= 8'h00;
      p0_s2 <= 8'h00;
      p0_s3 <= 8'h00;
      p0_f <= 8'h00;
      p1_s1 <= 8'h00;
      p1_s2 <= 8'h00;
      p1_s3 <= 8'h00;
      p1_f <= 8'h00;
    end
    else
    begin
      p0_s1 <= pin_in0;
      p0_s2 <= p0_s1;
      p0_s3 <= p0_s2;
      p0_f <= (p0_s2 & p0_s3) | (p0_f & (p0_s2 | p0_s3));
      p1_s1 <= pin_in1;
      p1_s2 <= p1_s1;
      p1_s3 <= p1_s2;
      p1_f <= (p1_s2 & p1_s3) | (p1_f & (p1_s2 | p1_s3));
    end
  end

  // pin read: a disabled buffer reads zero
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_read0 <= 8'h00;
      pin_read1 <= 8'h00;
    end
    else
    begin
      pin_read0 <= p0_f & ~dis0;
      pin_read1 <= p1_f & ~dis1;
    end
  end

  // trigger: rising edge of the raw event flag; interrupt enables
  // never gate it, and a flag left high cannot retrigger
  assign sel_flag = trig_pick(cfg[DCX_CFG_SEL_MSB:DCX_CFG_SEL_LSB],
                              event_flags);
  assign trig_edge = cfg[DCX_CFG_AUTO_BIT] && sel_flag &&
                     !flag_prev;
  assign trig_go = trig_edge && cfg[DCX_CFG_EN_BIT] &&
                   (state == DCX_CV_IDLE);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_prev <= 1'b0;
      en_prev <= 1'b0;
    end
    else
    begin
      flag_prev <= sel_flag;
      en_prev <= cfg[DCX_CFG_EN_BIT];
    end
  end

  // layout chosen at high-write time, so a left_adjust change waits
  assign next_code = code_from_bytes(cfg[DCX_CFG_LEFT_BIT], w_byte,
                                     lo_byte);

  // staged value: a low write disarms, the high write arms
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      staged <= DCX_CODE_RST;
      armed <= 1'b0;
    end
    else if (hi_write)
    begin
      staged <= next_code;
      armed <= 1'b1;
    end
    else if (lo_write)
      armed <= 1'b0;
  end

  // shadow code seen by the converter core
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      conv_code <= DCX_CODE_RST;
    else if (!cfg[DCX_CFG_AUTO_BIT] && hi_write)
      conv_code <= next_code;
    else if (trig_go && armed)
      conv_code <= staged;
  end

  // start: trigger edge in auto mode, else high write or enable rise
  assign start_req = cfg[DCX_CFG_EN_BIT] && (state == DCX_CV_IDLE) &&
    (cfg[DCX_CFG_AUTO_BIT] ? trig_edge :
     (hi_write || !en_prev));

  // conversion timer; clearing enable aborts at once
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= DCX_CV_IDLE;
      settle_cnt <= 16'h0000;
    end
    else
    begin
      unique case (state)
        DCX_CV_IDLE:
        begin
          if (start_req)
          begin
            state <= DCX_CV_BUSY;
            settle_cnt <= 16'(SETTLE_CYCLES - 1);
          end
        end
        DCX_CV_BUSY:
        begin
          if (!cfg[DCX_CFG_EN_BIT] || settle_cnt == 16'h0000)
            state <= DCX_CV_IDLE;
          else
            settle_cnt <= settle_cnt - 16'h0001;
        end
      endcase
    end
  end

  // start pulse to the core, one clock per conversion
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      conv_start <= 1'b0;
    else
      conv_start <= start_req;
  end

  assign conv_busy = (state == DCX_CV_BUSY);
  assign converter_on = cfg[DCX_CFG_EN_BIT];
  assign output_pin_drive = cfg[DCX_CFG_OE_BIT];

  // read decode; bit 3 of config is always zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_map = 1'b1;
    unique case (s_axi_araddr)
      DCX_OFS_CFG: rd_word[7:0] = cfg;
      DCX_OFS_HIGH: rd_word[7:0] = hi_byte;
      DCX_OFS_LOW: rd_word[7:0] = lo_byte;
      DCX_OFS_DIS0: rd_word[7:0] = dis0;
      DCX_OFS_DIS1: rd_word[7:0] = dis1;
      DCX_OFS_STAT:
      begin
        rd_word[9:0] = conv_code;
        rd_word[DCX_STAT_BUSY_BIT] = conv_busy;
        rd_word[DCX_STAT_ARMED_BIT] = armed;
      end
      default: rd_map = 1'b0;
    endcase
  end

  // read channel: one read at a time, answered the next clock
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= DCX_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_map ? DCX_RESP_OKAY : DCX_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // checks
  a_pin0_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (pin_read0 & $past(dis0)) == 8'h00)
    else $error("disabled bank 0 pin read not zero");

  a_pin1_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (pin_read1 & $past(dis1)) == 8'h00)
    else $error("disabled bank 1 pin read not zero");

  a_manual_update: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    hi_write && !cfg[DCX_CFG_AUTO_BIT] |=>
      conv_code == $past(next_code))
    else $error("manual high write did not update code");

  a_low_blocks: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    lo_write && !trig_go |=> $stable(conv_code))
    else $error("low write changed the code");

  a_auto_holds: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    hi_write && cfg[DCX_CFG_AUTO_BIT] && !trig_go |=>
      $stable(conv_code))
    else $error("auto mode code changed without trigger");

  a_trig_start: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    trig_go |=> conv_start && conv_busy)
    else $error("trigger edge did not start conversion");

  a_busy_ignore: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    conv_busy && trig_edge |=> !conv_start)
    else $error("edge during conversion was not ignored");

  a_level_norestart: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    cfg[DCX_CFG_AUTO_BIT] && $fell(conv_busy) && sel_flag && flag_prev
      |=> !conv_start)
    else $error("high trigger level restarted conversion");

  a_off_idle: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !converter_on |=> !conv_busy && !conv_start)
    else $error("converter busy while disabled");

  a_cfg_reserved: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    cfg_write |=> !cfg[3] && output_pin_drive == $past(w_byte[1]))
    else $error("config write mishandled reserved or output bit");

endmodule : dcx_top

/* File: tb/dcx_events.sv */
// event flag sources that feed the trigger input of the converter control
`timescale 1ns/1ps
module dcx_events
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // requests from the bench: one bit per source
  input wire logic [7:0] raise_req,
  input wire logic [7:0] clear_req,
  // flag levels seen by the block
  output logic [7:0] event_flags
);
  // a flag stays set until software clears it, whatever its interrupt
  // enable says, so a second event cannot rise until then
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      event_flags <= 8'h00;
    else
      event_flags <= (event_flags | raise_req) & ~clear_req;
  end
endmodule : dcx_events

/* File: tb/dcx_top_bench.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module dcx_top_bench;
  import dcx_pkg::*;
  localparam int SETTLE = 8; // short settle keeps the run brief
  // clock, reset and bus wires
  logic clk_sys, arst_n;
  logic [7:0] awaddr, araddr, flags, raise_req, clear_req;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, got;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  // pins and converter side
  logic [7:0] pin_in0, pin_in1, pin_read0, pin_read1, buf_off0, buf_off1;
  logic [9:0] conv_code, expc;
  logic converter_on, output_pin_drive, conv_start, conv_busy;
  int errors, tests_run, starts, cycles, s;

  dcx_top #(.SETTLE_CYCLES(SETTLE)) u_dcx_top
  (
    .clk_sys(clk_sys), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_flags(flags),
    .pin_in0(pin_in0), .pin_in1(pin_in1), .pin_read0(pin_read0),
    .pin_read1(pin_read1), .buf_off0(buf_off0), .buf_off1(buf_off1),
    .conv_code(conv_code), .converter_on(converter_on),
    .output_pin_drive(output_pin_drive), .conv_start(conv_start),
    .conv_busy(conv_busy)
  );

  dcx_events u_dcx_events
  (
    .clk_sys(clk_sys), .arst_n(arst_n), .raise_req(raise_req),
    .clear_req(clear_req), .event_flags(flags)
  );

  // free-running clock, 50 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // conversion starts and the hang limit
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (conv_start === 1'b1)
      starts <= starts + 1;
    if (cycles == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] seen);
    tests_run++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      errors++;
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // one write; each handshake and the answer are judged at the rising
  // edge itself, where the block samples them, and released just after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic tb;
    int n;
    n = 0;
    tb = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb && n < 50)
    begin
      @(posedge clk_sys);
      tb = bvalid & bready;
      resp = bresp;
      if (awvalid & awready)
        awvalid <= 1'b0;
      if (wvalid & wready)
        wvalid <= 1'b0;
      if (tb)
        bready <= 1'b0;
      n++;
    end
    if (!tb)
      chk("write answer", 32'h1, 32'h0);
  endtask : wr

  // one read, same sampling scheme as the write
  task automatic rd(input logic [7:0] a);
    logic tr;
    int n;
    n = 0;
    tr = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr && n < 50)
    begin
      @(posedge clk_sys);
      tr = rvalid & rready;
      got = rdata;
      resp = rresp;
      if (arvalid & arready)
        arvalid <= 1'b0;
      if (tr)
        rready <= 1'b0;
      n++;
    end
    if (!tr)
      chk("read answer", 32'h1, 32'h0);
  endtask : rd

  task automatic rdchk(input string what, input logic [7:0] a,
    input logic [31:0] exp);
    rd(a);
    chk(what, exp, got);
  endtask : rdchk

  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge clk_sys);
    while (conv_busy !== 1'b0 && n < 100)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("idle", 32'h0, {31'h0, conv_busy});
  endtask : wait_idle

  // one-cycle requests to the event source model
  task automatic trig(input int sel);
    @(posedge clk_sys);
    raise_req <= 8'h01 << sel;
    @(posedge clk_sys);
    raise_req <= 8'h00;
  endtask : trig

  task automatic clr(input int sel);
    @(posedge clk_sys);
    clear_req <= 8'h01 << sel;
    @(posedge clk_sys);
    clear_req <= 8'h00;
  endtask : clr

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    // every input defined at time zero, reset held four cycles
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    {raise_req, clear_req, wdata, errors, tests_run, starts} = '0;
    wstrb = 4'hF;
    pin_in0 = 8'hFF;
    pin_in1 = 8'hFF;
    cycles = 0;
    arst_n = 1'b0;
    tick(4);
    arst_n <= 1'b1;
    tick(3);
    // registers: reset values, reserved bit, unmapped place
    rdchk("config reset", DCX_OFS_CFG, 32'h0);
    rdchk("high reset", DCX_OFS_HIGH, 32'h0);
    rdchk("low reset", DCX_OFS_LOW, 32'h0);
    wr(DCX_OFS_CFG, 8'hFF);
    chk("write resp", DCX_RESP_OKAY, resp);
    rdchk("config bit 3", DCX_OFS_CFG, 32'hF7);
    wr(DCX_OFS_CFG, 8'h00);
    rd(8'h18);
    chk("unmapped resp", DCX_RESP_SLVERR, resp);
    wr(8'h18, 8'h00);
    chk("unmapped write", DCX_RESP_SLVERR, resp);
    wstrb <= 4'h0;
    wr(DCX_OFS_LOW, 8'h55);
    wstrb <= 4'hF;
    rdchk("no lane write", DCX_OFS_LOW, 32'h0);
    $display("test registers done");
    // input buffer disable: pins all high, every bit written one
    wr(DCX_OFS_DIS0, 8'hFF);
    wr(DCX_OFS_DIS1, 8'hFF);
    rdchk("disable first", DCX_OFS_DIS0, 32'h6D);
    rdchk("disable second", DCX_OFS_DIS1, 32'h26);
    tick(10);
    chk("buffer off first", 32'h6D, buf_off0);
    chk("pin read first", 32'h92, pin_read0);
    chk("buffer off second", 32'h26, buf_off1);
    chk("pin read second", 32'hD9, pin_read1);
    wr(DCX_OFS_DIS0, 8'h00);
    tick(10);
    chk("pin read enabled", 32'hFF, pin_read0);
    pin_in0 <= 8'h0F;
    tick(8);
    chk("pin follows", 32'h0F, pin_read0);
    $display("test input disable done");
    // manual mode, right then left layout
    wr(DCX_OFS_CFG, 8'h01);
    wait_idle();
    s = starts;
    wr(DCX_OFS_LOW, 8'hF4);
    tick(2);
    chk("code after low", 32'h0, conv_code);
    wr(DCX_OFS_HIGH, 8'h02);
    tick(2);
    chk("code right", 32'h2F4, conv_code);
    chk("busy", 32'h1, conv_busy);
    wait_idle();
    chk("manual starts", s + 1, starts);
    wr(DCX_OFS_CFG, 8'h05);
    tick(2);
    chk("code kept", 32'h2F4, conv_code);
    wr(DCX_OFS_HIGH, 8'hAB);
    tick(2);
    chk("code left", 32'h2AF, conv_code);
    wr(DCX_OFS_CFG, 8'h03);
    tick(2);
    chk("pin drive on", 32'h1, output_pin_drive);
    chk("converter on", 32'h1, converter_on);
    wr(DCX_OFS_CFG, 8'h00);
    tick(2);
    chk("pin drive off", 32'h0, output_pin_drive);
    chk("converter off", 32'h0, converter_on);
    $display("test manual mode done");
    // auto mode: every source, a foreign flag first
    expc = 10'h2AF;
    for (int sel = 0; sel < 8; sel++)
    begin
      wr(DCX_OFS_CFG, {1'b1, sel[2:0], 4'h1});
      wait_idle();
      wr(DCX_OFS_LOW, {sel[2:0], 5'h00});
      wr(DCX_OFS_HIGH, 8'h01);
      tick(2);
      chk("staged only", expc, conv_code);
      s = starts;
      trig(sel ^ 1);
      tick(4);
      chk("foreign flag", s, starts);
      clr(sel ^ 1);
      trig(sel);
      tick(4);
      expc = {2'b01, sel[2:0], 5'h00};
      chk("auto start", s + 1, starts);
      chk("auto code", expc, conv_code);
      wait_idle();
      clr(sel);
    end
    wr(DCX_OFS_CFG, 8'h31);
    wait_idle();
    s = starts;
    trig(3);
    tick(4);
    chk("select unused", s, starts);
    clr(3);
    $display("test trigger sources done");
    // edges in a conversion, flag high at its end, low byte alone
    wr(DCX_OFS_CFG, 8'h81);
    wr(DCX_OFS_LOW, 8'h10);
    wr(DCX_OFS_HIGH, 8'h03);
    wait_idle();
    s = starts;
    trig(0);
    tick(1);
    clr(0);
    trig(0);
    wait_idle();
    tick(3);
    chk("no restart", s + 1, starts);
    chk("trigger code", 32'h310, conv_code);
    rdchk("status armed", DCX_OFS_STAT, 32'hB10);
    clr(0);
    wr(DCX_OFS_LOW, 8'h77);
    trig(0);
    tick(4);
    chk("next event", s + 2, starts);
    chk("low alone", 32'h310, conv_code);
    wait_idle();
    $display("test trigger timing done");
    report_and_stop();
  end
endmodule : dcx_top_bench
